// file: rtl/rbas_pkg.sv
package rbas_pkg;

  // ==========================================================================
  // Widths and access ports
  // ==========================================================================
  localparam int DW    = 16;
  localparam int AW    = 3;
  localparam int NPORT = 3;

  // Access paths: serial slave (SPI or I2C), in-band frames, management data.
  localparam logic [1:0] PORT_SER  = 2'h0;
  localparam logic [1:0] PORT_INB  = 2'h1;
  localparam logic [1:0] PORT_MIIM = 2'h2;

  // ==========================================================================
  // Register map, one 16-bit word per address
  // ==========================================================================
  localparam logic [AW-1:0] ADDR_STATUS = 3'h0;
  localparam logic [AW-1:0] ADDR_RDCLR  = 3'h1;
  localparam logic [AW-1:0] ADDR_WRONLY = 3'h2;
  localparam logic [AW-1:0] ADDR_W1C    = 3'h3;
  localparam logic [AW-1:0] ADDR_LLOW   = 3'h4;
  localparam logic [AW-1:0] ADDR_LHIGH  = 3'h5;
  localparam logic [AW-1:0] ADDR_SELFCL = 3'h6;
  localparam logic [AW-1:0] ADDR_CTRL   = 3'h7;

  // Transceiver window reachable from the management data interface.
  localparam logic [AW-1:0] PHY_ADDR_LO = 3'h4;
  localparam logic [AW-1:0] PHY_ADDR_HI = 3'h5;

  // ==========================================================================
  // Field masks and reset values
  // ==========================================================================
  localparam logic [DW-1:0] CTRL_IMPL_MASK = 16'h00ff;
  localparam logic [DW-1:0] WO_READ_VALUE  = 16'h0000;
  localparam logic [DW-1:0] RST_RDCLR      = 16'h0000;
  localparam logic [DW-1:0] RST_WRONLY     = 16'h0000;
  localparam logic [DW-1:0] RST_W1C        = 16'h0000;
  localparam logic [DW-1:0] RST_LLOW       = 16'h0000;
  localparam logic [DW-1:0] RST_LHIGH      = 16'h0000;
  localparam logic [DW-1:0] RST_SELFCL     = 16'h0000;
  localparam logic [DW-1:0] RST_CTRL       = 16'h0000;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_EXEC,
    ARB_DONE
  } rbas_arb_e;

endpackage

// file: rtl/rbas_acc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rbas_acc_if;
  import rbas_pkg::*;

  logic          exec;
  logic          abort;
  logic          we;
  logic [1:0]    src;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;

  modport arb  (output exec, abort, we, src, addr, wdata);
  modport bank (input exec, abort, we, src, addr, wdata);

endinterface

`default_nettype wire

// file: rtl/rbas_port_arb.sv
`timescale 1ns/1ps
`default_nettype none

module rbas_port_arb
  import rbas_pkg::*;
(
  // Clock and reset.
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  // Host access ports.
  input  wire logic [NPORT-1:0]            i_req,
  input  wire logic [NPORT-1:0]            i_we,
  input  wire logic [NPORT-1:0]            i_abort,
  input  wire logic [NPORT-1:0][AW-1:0]    i_addr,
  input  wire logic [NPORT-1:0][DW-1:0]    i_wdata,
  // Selected access towards the bank.
  rbas_acc_if.arb                          acc
);

  function automatic logic [1:0] first_req(input logic [NPORT-1:0] req);
    first_req = 2'h0;
    for (int i = NPORT - 1; i >= 0; i--) begin
      if (req[i]) begin
        first_req = 2'(i);
      end
    end
  endfunction

  rbas_arb_e     state_q, state_d;
  logic [1:0]    sel_q, sel_d;
  logic          we_q, we_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;

  // ==========================================================================
  // Grant one port at a time; the lowest index wins
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    sel_d   = sel_q;
    we_d    = we_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    unique case (state_q)
      ARB_IDLE: begin
        if (|i_req) begin
          sel_d   = first_req(i_req);
          we_d    = i_we[sel_d];
          addr_d  = i_addr[sel_d];
          wdata_d = i_wdata[sel_d];
          state_d = ARB_EXEC;
        end
      end
      ARB_EXEC: state_d = ARB_DONE;
      ARB_DONE: state_d = ARB_IDLE;
      default:  state_d = ARB_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= ARB_IDLE;
      sel_q   <= 2'h0;
      we_q    <= 1'b0;
      addr_q  <= 3'h0;
      wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      sel_q   <= sel_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign acc.exec  = (state_q == ARB_EXEC);
  assign acc.abort = i_abort[sel_q];
  assign acc.we    = we_q;
  assign acc.src   = sel_q;
  assign acc.addr  = addr_q;
  assign acc.wdata = wdata_q;

endmodule

`default_nettype wire

// file: rtl/rbas_reg_bank.sv
// What this block does
// - Read-only registers ignore every host write.
// - Read-clear returns contents, then clears; writes ignored.
// - Write-only registers read back a meaningless constant.
// - Writing one clears a bit; zero leaves it.
// - Latch-low bit stays low until read.
// - Reading latch-low releases it to live condition.
// - Latch-high bit stays high until read.
// - Reading latch-high releases it to live condition.
// - Self-clearing bits clear themselves; zero writes ignored.
// - Serial and in-band ports reach the whole register space.
// - Management data port reaches the transceiver registers.
`timescale 1ns/1ps
`default_nettype none

module rbas_reg_bank
  import rbas_pkg::*;
(
  // Clock and reset.
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  // Host access ports: serial slave, in-band, management data.
  input  wire logic [NPORT-1:0]            i_req,
  input  wire logic [NPORT-1:0]            i_we,
  input  wire logic [NPORT-1:0]            i_abort,
  input  wire logic [NPORT-1:0][AW-1:0]    i_addr,
  input  wire logic [NPORT-1:0][DW-1:0]    i_wdata,
  // Host access answers.
  output logic      [NPORT-1:0]            o_ack,
  output logic                             o_err,
  output logic      [DW-1:0]               o_rdata,
  // Status sources.
  input  wire logic [DW-1:0]               i_live_status,
  input  wire logic [DW-1:0]               i_rdclr_event,
  input  wire logic [DW-1:0]               i_w1c_event,
  input  wire logic [DW-1:0]               i_llow_cond,
  input  wire logic [DW-1:0]               i_lhigh_cond,
  input  wire logic [DW-1:0]               i_selfcl_done,
  // Control consumers.
  output logic      [DW-1:0]               o_ctrl,
  output logic      [DW-1:0]               o_wronly_ctrl,
  output logic      [DW-1:0]               o_selfcl_cmd,
  output logic                             o_attention
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // One-hot decode of a word address into eight word strobes.
  function automatic logic [7:0] addr_dec(input logic [AW-1:0] addr);
    addr_dec = 8'h01 << addr;
  endfunction

  // A set in the same cycle as a clear wins.
  function automatic logic [DW-1:0] set_clr(input logic [DW-1:0] cur,
                                             input logic [DW-1:0] set,
                                             input logic [DW-1:0] clr);
    set_clr = (cur & ~clr) | set;
  endfunction

  // True for the words that the management data port may reach.
  function automatic logic in_phy(input logic [AW-1:0] addr);
    in_phy = (addr >= PHY_ADDR_LO) && (addr <= PHY_ADDR_HI);
  endfunction

  // ==========================================================================
  // Access selection
  // ==========================================================================
  rbas_acc_if acc ();

  rbas_port_arb u_arb (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_req   (i_req),
    .i_we    (i_we),
    .i_abort (i_abort),
    .i_addr  (i_addr),
    .i_wdata (i_wdata),
    .acc     (acc.arb)
  );

  logic       refused;
  logic       done;
  logic       rd_done;
  logic       wr_done;
  logic [7:0] hit;

  // Only an access that reaches its execute cycle unaborted has any effect.
  // The management data port is confined to the transceiver window.
  always_comb begin
    refused = (acc.src == PORT_MIIM) && !in_phy(acc.addr);
    done    = acc.exec && !acc.abort;
    rd_done = done && !acc.we && !refused;
    wr_done = done && acc.we && !refused;
    hit     = addr_dec(acc.addr);
  end

  // ==========================================================================
  // Per-word strobes
  // ==========================================================================
  logic [7:0]    rd_strb;
  logic [7:0]    wr_strb;
  logic [DW-1:0] rdclr_clr;
  logic [DW-1:0] w1c_clr;
  logic          llow_rel;
  logic          lhigh_rel;
  logic          wronly_ld;
  logic          ctrl_ld;
  logic [DW-1:0] selfcl_set;

  // Each strobe lives only in the cycle in which an access completes, so one
  // host transfer can never apply its side effect twice. Words without a
  // strobe here have no write path at all.
  always_comb begin
    rd_strb    = rd_done ? hit : 8'h00;
    wr_strb    = wr_done ? hit : 8'h00;
    rdclr_clr  = {DW{rd_strb[ADDR_RDCLR]}};
    w1c_clr    = wr_strb[ADDR_W1C] ? acc.wdata : 16'h0000;
    llow_rel   = rd_strb[ADDR_LLOW];
    lhigh_rel  = rd_strb[ADDR_LHIGH];
    wronly_ld  = wr_strb[ADDR_WRONLY];
    ctrl_ld    = wr_strb[ADDR_CTRL];
    selfcl_set = wr_strb[ADDR_SELFCL] ? acc.wdata : 16'h0000;
  end

  // ==========================================================================
  // Read-clear and write-one-clear registers
  // ==========================================================================
  logic [DW-1:0] rdclr_q, rdclr_d;
  logic [DW-1:0] w1c_q, w1c_d;

  always_comb begin
    rdclr_d = set_clr(rdclr_q, i_rdclr_event, rdclr_clr);
    w1c_d   = set_clr(w1c_q, i_w1c_event, w1c_clr);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdclr_q <= RST_RDCLR;
      w1c_q   <= RST_W1C;
    end else begin
      rdclr_q <= rdclr_d;
      w1c_q   <= w1c_d;
    end
  end

  // ==========================================================================
  // Latched status registers
  // ==========================================================================
  logic [DW-1:0] llow_q, llow_d;
  logic [DW-1:0] lhigh_q, lhigh_d;

  // A completed read reloads the live condition; otherwise a low or a high
  // sticks. A condition present in the read cycle is kept by the reload.
  always_comb begin
    if (llow_rel) begin
      llow_d = i_llow_cond;
    end else begin
      llow_d = llow_q & i_llow_cond;
    end
    if (lhigh_rel) begin
      lhigh_d = i_lhigh_cond;
    end else begin
      lhigh_d = lhigh_q | i_lhigh_cond;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      llow_q  <= RST_LLOW;
      lhigh_q <= RST_LHIGH;
    end else begin
      llow_q  <= llow_d;
      lhigh_q <= lhigh_d;
    end
  end

  // ==========================================================================
  // Control registers: write-only, self-clearing, plain control
  // ==========================================================================
  logic [DW-1:0] wronly_q, wronly_d;
  logic [DW-1:0] selfcl_q, selfcl_d;
  logic [DW-1:0] ctrl_q, ctrl_d;

  // A self-clearing bit is set by a host one and dropped when its consumer
  // reports the action finished; a host set in that same cycle wins.
  always_comb begin
    wronly_d = wronly_q;
    ctrl_d   = ctrl_q;
    if (wronly_ld) begin
      wronly_d = acc.wdata;
    end
    // Reserved control bits never reach storage, whatever the host sends.
    if (ctrl_ld) begin
      ctrl_d = acc.wdata & CTRL_IMPL_MASK;
    end
    selfcl_d = set_clr(selfcl_q, selfcl_set, i_selfcl_done);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wronly_q <= RST_WRONLY;
      selfcl_q <= RST_SELFCL;
      ctrl_q   <= RST_CTRL;
    end else begin
      wronly_q <= wronly_d;
      selfcl_q <= selfcl_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // ==========================================================================
  // Read data and answers
  // ==========================================================================
  logic [DW-1:0]    rdata_q, rdata_d;
  logic [NPORT-1:0] ack_q, ack_d;
  logic             err_q, err_d;
  logic [DW-1:0]    rd_mux;

  // Writes to the status, read-clear, latch-low and latch-high words have no
  // path into their storage, so they fall through here untouched.
  always_comb begin
    unique case (acc.addr)
      ADDR_STATUS: rd_mux = i_live_status;
      ADDR_RDCLR:  rd_mux = rdclr_q;
      ADDR_WRONLY: rd_mux = WO_READ_VALUE;
      ADDR_W1C:    rd_mux = w1c_q;
      ADDR_LLOW:   rd_mux = llow_q;
      ADDR_LHIGH:  rd_mux = lhigh_q;
      ADDR_SELFCL: rd_mux = selfcl_q;
      ADDR_CTRL:   rd_mux = ctrl_q & CTRL_IMPL_MASK;
    endcase
  end

  always_comb begin
    rdata_d = rdata_q;
    ack_d   = '0;
    err_d   = 1'b0;
    if (done) begin
      for (int i = 0; i < NPORT; i++) begin
        ack_d[i] = (acc.src == 2'(i));
      end
      err_d = refused;
      if (!acc.we) begin
        rdata_d = refused ? 16'h0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
      ack_q   <= '0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
    end
  end

  // ==========================================================================
  // Attention summary
  // ==========================================================================
  logic attn_q, attn_d;

  // Pending read-clear, write-one-clear or latch-high bits ask for service.
  // The flag trails its sources by one cycle because it is registered.
  always_comb begin
    attn_d = (|rdclr_q) || (|w1c_q) || (|lhigh_q);
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      attn_q <= 1'b0;
    end else begin
      attn_q <= attn_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_ack         = ack_q;
  assign o_err         = err_q;
  assign o_rdata       = rdata_q;
  assign o_ctrl        = ctrl_q;
  assign o_wronly_ctrl = wronly_q;
  assign o_selfcl_cmd  = selfcl_q;
  assign o_attention   = attn_q;

endmodule

`default_nettype wire

// file: verif/rbas_reg_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rbas_reg_bank_checker
  import rbas_pkg::*;
(
  // Clock and reset.
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  // Host side.
  input  wire logic [NPORT-1:0]         i_req,
  input  wire logic [NPORT-1:0]         i_we,
  input  wire logic [NPORT-1:0][AW-1:0] i_addr,
  input  wire logic [NPORT-1:0]         o_ack,
  input  wire logic                     o_err,
  // Control side.
  input  wire logic [DW-1:0]            i_selfcl_done,
  input  wire logic [DW-1:0]            o_ctrl,
  input  wire logic [DW-1:0]            o_wronly_ctrl,
  input  wire logic [DW-1:0]            o_selfcl_cmd
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Words written by a completed access from a full-access port, and whether
  // the management data port addresses the transceiver window.
  logic [7:0] wr_hit;
  logic       mgmt_ok;
  always_comb begin
    wr_hit  = 8'h00;
    mgmt_ok = i_addr[2] inside {[PHY_ADDR_LO:PHY_ADDR_HI]};
    for (int i = 0; i < 2; i++) begin
      if (o_ack[i] && i_we[i]) begin
        wr_hit[i_addr[i]] = 1'b1;
      end
    end
  end

  sequence s_done;
    |o_ack;
  endsequence
  sequence s_quiet;
    o_ack == '0;
  endsequence

  a_ack_single: assert property ($onehot0(o_ack))
    else $error("two ports acknowledged together");
  a_ack_pulse: assert property (s_done |=> s_quiet)
    else $error("acknowledge longer than one cycle");
  a_ack_has_req: assert property (s_done |-> (o_ack & $past(i_req, 2)) == o_ack)
    else $error("acknowledge without request");
  a_err_mgmt_only: assert property (o_err |-> o_ack[2])
    else $error("error flag outside management answer");
  a_mgmt_window: assert property (o_ack[2] |-> o_err == !mgmt_ok)
    else $error("management window decision wrong");
  a_ctrl_reserved: assert property ((o_ctrl & ~CTRL_IMPL_MASK) == '0)
    else $error("reserved control bits set");
  a_ctrl_by_write: assert property ($changed(o_ctrl) && !$past(i_rst) |-> wr_hit[ADDR_CTRL])
    else $error("control changed without write");
  a_wo_by_write: assert property ($changed(o_wronly_ctrl) && !$past(i_rst) |-> wr_hit[ADDR_WRONLY])
    else $error("write-only word changed without write");
  a_sc_set_only: assert property ((o_selfcl_cmd & ~$past(o_selfcl_cmd)) != '0 |-> wr_hit[ADDR_SELFCL])
    else $error("self-clearing bit set without write");
  a_sc_clear_done: assert property (
    ($past(o_selfcl_cmd) & ~o_selfcl_cmd & ~$past(i_selfcl_done)) == '0)
    else $error("self-clearing bit dropped without done");
endmodule

bind rbas_reg_bank rbas_reg_bank_checker chk_u (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .o_ack(o_ack), .o_err(o_err),
  .i_selfcl_done(i_selfcl_done), .o_ctrl(o_ctrl), .o_wronly_ctrl(o_wronly_ctrl),
  .o_selfcl_cmd(o_selfcl_cmd));
`default_nettype wire

// file: verif/rbas_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rbas_host_model
  import rbas_pkg::*;
(
  // Clock and answers.
  input  wire logic [0:0]               i_mclk,
  input  wire logic [NPORT-1:0]         i_ack,
  input  wire logic                     i_err,
  input  wire logic [DW-1:0]            i_rdata,
  // Requests.
  output logic      [NPORT-1:0]         o_req,
  output logic      [NPORT-1:0]         o_we,
  output logic      [NPORT-1:0]         o_abort,
  output logic      [NPORT-1:0][AW-1:0] o_addr,
  output logic      [NPORT-1:0][DW-1:0] o_wdata
);
  initial begin
    o_req = '0;
    o_we = '0;
    o_abort = '0;
    o_addr = '0;
    o_wdata = '0;
  end

  // One access; ok is low when an answer is missing or an aborted one answers.
  task automatic xfer(input int p, input logic w, input logic [AW-1:0] a,
                      input logic [DW-1:0] d, input logic b,
                      output logic [DW-1:0] rd, output logic er, output logic ok);
    ok = b;
    rd = '0;
    er = 1'b0;
    o_we[p] = w;
    o_addr[p] = a;
    o_wdata[p] = (a == ADDR_CTRL) ? (d & CTRL_IMPL_MASK) : d;
    o_req[p] = 1'b1;
    @(posedge i_mclk);
    #1 o_abort[p] = b;
    if (b) begin
      @(posedge i_mclk);
      #1 o_req[p] = 1'b0;
      o_abort[p] = 1'b0;
      repeat (3) begin
        @(posedge i_mclk);
        if (i_ack[p] !== 1'b0) ok = 1'b0;
      end
    end else begin
      for (int n = 0; n < 8 && !ok; n++) begin
        @(posedge i_mclk);
        if (i_ack[p] === 1'b1) begin
          ok = 1'b1;
          rd = i_rdata;
          er = i_err;
        end
      end
    end
    #1 o_req[p] = 1'b0;
    o_addr[p] = ~a;
    o_wdata[p] = ~d;
    @(posedge i_mclk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_rbas_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rbas_reg_bank;
  import rbas_pkg::*;
  logic                     i_mclk = 1'b0;
  logic                     i_rst = 1'b1;
  logic [NPORT-1:0]         req, we, ab, ack;
  logic [NPORT-1:0][AW-1:0] addr;
  logic [NPORT-1:0][DW-1:0] wdata;
  logic                     err, attn, er;
  logic [DW-1:0]            rdata, ctrl, wctl, scmd, rd;
  logic [DW-1:0]            live = '0, rce = '0, wce = '0, llc = '0, lhc = '0, scd = '0;
  logic [31:0]              seed = 32'he0f2_492d;
  int                       bad_count = 0;
  int                       checks_done = 0;

  always #5 i_mclk = ~i_mclk;

  rbas_reg_bank dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .i_we(we),
    .i_abort(ab), .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_err(err),
    .o_rdata(rdata), .i_live_status(live), .i_rdclr_event(rce), .i_w1c_event(wce),
    .i_llow_cond(llc), .i_lhigh_cond(lhc), .i_selfcl_done(scd), .o_ctrl(ctrl),
    .o_wronly_ctrl(wctl), .o_selfcl_cmd(scmd), .o_attention(attn));
  rbas_host_model host_u (.i_mclk(i_mclk), .i_ack(ack), .i_err(err), .i_rdata(rdata),
    .o_req(req), .o_we(we), .o_abort(ab), .o_addr(addr), .o_wdata(wdata));

  function logic [DW-1:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[DW-1:0];
  endfunction
  function logic [DW-1:0] w1c_next(input logic [DW-1:0] q, ev, wr);
    return (q | ev) & ~wr;
  endfunction

  task close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic acc(input int p, input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, input logic b);
    logic ok;
    host_u.xfer(p, w, a, d, b, rd, er, ok);
    if (ok !== 1'b1) begin
      $display("Error ack port %0d expected 1 seen %b", p, ok);
      bad_count++;
      close_out();
    end
  endtask
  task automatic pulse(ref logic [DW-1:0] s, input logic [DW-1:0] v, input logic [DW-1:0] z);
    s = v;
    @(posedge i_mclk);
    #1 s = z;
  endtask

  initial begin
    int p;
    logic [DW-1:0] v, w, m;
    m = '0;
    repeat (4) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    chk("ctrl_reset", '0, ctrl);
    for (int i = 0; i < 4; i++) begin
      p = int'(rnd() & 16'h0001);
      live = rnd();
      acc(p, 1'b1, ADDR_STATUS, ~live, 1'b0);
      acc(p, 1'b0, ADDR_STATUS, '0, 1'b0);
      chk("status", live, rd);
      v = rnd() | 16'h0001;
      pulse(rce, v, '0);
      acc(p, 1'b1, ADDR_RDCLR, 16'hffff, 1'b0);
      chk("attention_set", 16'h0001, 16'(attn));
      acc(p, 1'b0, ADDR_RDCLR, '0, 1'b1);
      acc(p, 1'b0, ADDR_RDCLR, '0, 1'b0);
      chk("rdclr", v, rd);
      acc(p, 1'b0, ADDR_RDCLR, '0, 1'b0);
      chk("rdclr_again", '0, rd);
      chk("attention_clr", 16'(m != '0), 16'(attn));
      w = rnd();
      acc(p, 1'b1, ADDR_WRONLY, w, 1'b0);
      chk("wronly", w, wctl);
      v = rnd();
      w = rnd();
      pulse(wce, v, '0);
      acc(p, 1'b1, ADDR_W1C, w, 1'b0);
      m = w1c_next(m, v, w);
      acc(p, 1'b0, ADDR_W1C, '0, 1'b0);
      chk("w1c", m, rd);
      llc = 16'hffff;
      acc(2, 1'b0, ADDR_LLOW, '0, 1'b0);
      v = rnd();
      pulse(llc, v, 16'hffff);
      acc(2, 1'b0, ADDR_LLOW, '0, 1'b0);
      chk("llow_held", v, rd);
      acc(2, 1'b0, ADDR_LLOW, '0, 1'b0);
      chk("llow_free", 16'hffff, rd);
      pulse(lhc, v, '0);
      acc(2, 1'b0, ADDR_LHIGH, '0, 1'b0);
      chk("lhigh_held", v, rd);
      acc(2, 1'b0, ADDR_LHIGH, '0, 1'b0);
      chk("lhigh_free", '0, rd);
      chk("mgmt_err", '0, 16'(er));
      w = rnd() | 16'h0001;
      acc(p, 1'b1, ADDR_SELFCL, w, 1'b0);
      acc(p, 1'b1, ADDR_SELFCL, '0, 1'b0);
      acc(p, 1'b0, ADDR_SELFCL, '0, 1'b0);
      chk("selfcl_read", w, rd);
      chk("selfcl_cmd", w, scmd);
      pulse(scd, 16'hffff, '0);
      chk("selfcl_done", '0, scmd);
      w = rnd();
      acc(p, 1'b1, ADDR_CTRL, w, 1'b0);
      chk("ctrl", w & CTRL_IMPL_MASK, ctrl);
      for (int k = 0; k < 8; k++) begin
        if (k != 4 && k != 5) begin
          acc(2, k[0], AW'(k), '0, 1'b0);
          chk("mgmt_refuse", 16'h0001, 16'(er));
        end
      end
      chk("ctrl_kept", w & CTRL_IMPL_MASK, ctrl);
    end
    close_out();
  end
endmodule
`default_nettype wire
